//--- panel_port_cfg.svh
// constants for the panel serial register port
`ifndef PANEL_PORT_CFG_SVH
`define PANEL_PORT_CFG_SVH
`define ADDR_IDENT 7'h00
`define ADDR_VCOM 7'h01
`define ADDR_MODE 7'h02
`define ADDR_SWRST 7'h0A
`define ADDR_READ_MAX 7'h3F
`define RST_VCOM 8'h68
`define RST_MODE 8'h00
`define FRAME_BITS 5'h10
`define ADDR_LAST_BIT 5'h08
`define PART_ID_DEF 3'h5
`define REV_ID_DEF 3'h2
`define MODE_SEL_BIT 0
`define SWRST_BIT 0
`define VCOM_AMP_MSB 7
`define VCOM_AMP_LSB 5
`define VCOM_DC_MSB 3
`define VCOM_DC_LSB 0
`endif

//--- panel_port_pkg.sv
// types shared by the panel serial register port
`default_nettype none
package panel_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_WDATA = 2'b10,
    ST_RDATA = 2'b11
  } frame_state_t;
endpackage
`default_nettype wire

//--- pin_sync_if.sv
// synchronised pin levels between the sampler and the port core
`default_nettype none
interface pin_sync_if;
  logic level;
  modport src (output level);
  modport dst (input level);
endinterface
`default_nettype wire

//--- pin_sync.sv
// three-stage pin sampler; a change counts once stages two and three agree
`default_nettype none
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_pin,
  pin_sync_if.src o_sync
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;
  always_comb begin
    stage_next = {stage_reg[1:0], i_pin};
    level_next = level_reg;
    if (stage_reg[2] == stage_reg[1]) begin
      level_next = stage_reg[2];
    end
    if (!i_rst_b) begin
      stage_next = {3{RST_VAL}};
      level_next = RST_VAL;
    end
  end
  always_ff @(posedge i_clk) begin
    stage_reg <= stage_next;
    level_reg <= level_next;
  end
  assign o_sync.level = level_reg;
endmodule // pin_sync
`default_nettype wire

//--- panel_serial_register_port.sv
// three-wire serial register port of the panel controller
`include "panel_port_cfg.svh"
`default_nettype none
module panel_serial_register_port #(
  parameter logic [2:0] PART_ID = `PART_ID_DEF, // arbitrary value
  parameter logic [2:0] REV_ID = `REV_ID_DEF // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_hw_reset_low_pin,
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  output logic [2:0] o_vcom_amp_trim,
  output logic [3:0] o_vcom_dc_level,
  output logic o_interface_mode_select,
  output logic o_regs_in_reset
);
  import panel_port_pkg::*;

  pin_sync_if sclk_s ();
  pin_sync_if cs_s ();
  pin_sync_if sda_s ();
  pin_sync_if rst_s ();

  pin_sync #(
    .RST_VAL(1'b0)
  ) u_sclk (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_sclk),
    .o_sync(sclk_s)
  );
  pin_sync #(
    .RST_VAL(1'b1)
  ) u_cs (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_cs_b),
    .o_sync(cs_s)
  );
  pin_sync #(
    .RST_VAL(1'b0)
  ) u_sda (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_sda),
    .o_sync(sda_s)
  );
  // reset pin sampler starts low so registers stay at defaults until the pin is seen high
  pin_sync #(
    .RST_VAL(1'b0)
  ) u_rst (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_hw_reset_low_pin),
    .o_sync(rst_s)
  );

  frame_state_t state_reg, state_next;
  logic sclk_d_reg, sclk_d_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [6:0] addr_reg, addr_next;
  logic [7:0] rd_shift_reg, rd_shift_next;
  logic [7:0] vcom_reg, vcom_next;
  logic [7:0] mode_reg, mode_next;
  logic sda_reg, sda_next;
  logic oe_reg, oe_next;
  logic in_rst_reg, in_rst_next;

  logic rise;
  logic fall;
  logic regs_clear;
  logic [7:0] rd_value;
  logic [7:0] byte_in;
  logic frame_abort;

  assign rise = sclk_s.level & ~sclk_d_reg;
  assign fall = ~sclk_s.level & sclk_d_reg;
  assign byte_in = {shift_reg[6:0], sda_s.level};
  assign frame_abort = cs_s.level | ~rst_s.level;

  // read mux; addresses up to 63 answer, unmapped ones read zero
  always_comb begin
    rd_value = 8'h00;
    if (addr_reg <= `ADDR_READ_MAX) begin
      unique case (addr_reg)
        `ADDR_IDENT: rd_value = {2'b00, PART_ID, REV_ID};
        `ADDR_VCOM: rd_value = vcom_reg;
        `ADDR_MODE: rd_value = mode_reg;
        default: rd_value = 8'h00;
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    // edge history follows the sampler through reset, so no false edge follows it
    sclk_d_next = sclk_s.level;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    rd_shift_next = rd_shift_reg;
    vcom_next = vcom_reg;
    mode_next = mode_reg;
    sda_next = sda_reg;
    oe_next = oe_reg;
    regs_clear = !rst_s.level;
    if (frame_abort) begin
      // partial bits are dropped so a retransmitted byte starts clean
      state_next = ST_IDLE;
      cnt_next = 5'h00;
      shift_next = 8'h00;
      oe_next = 1'b0;
      sda_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_ADDR: begin
          if (rise) begin
            shift_next = byte_in;
            cnt_next = cnt_reg + 5'h01;
            state_next = ST_ADDR;
            if (cnt_reg + 5'h01 == `ADDR_LAST_BIT) begin
              addr_next = byte_in[6:0];
              shift_next = 8'h00;
              state_next = byte_in[7] ? ST_RDATA : ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (rise && cnt_reg < `FRAME_BITS) begin
            shift_next = byte_in;
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg + 5'h01 == `FRAME_BITS) begin
              unique case (addr_reg)
                `ADDR_VCOM: vcom_next = byte_in;
                `ADDR_MODE: mode_next = byte_in;
                `ADDR_SWRST: regs_clear = byte_in[`SWRST_BIT];
                default: ; // identifier and unmapped writes dropped
              endcase
            end
          end
        end
        ST_RDATA: begin
          // host has let go of the line by now, so drive from the first fall
          if (fall && cnt_reg <= `FRAME_BITS) begin
            if (!oe_reg) begin
              sda_next = rd_value[7];
              rd_shift_next = {rd_value[6:0], 1'b0};
            end else begin
              sda_next = rd_shift_reg[7];
              rd_shift_next = {rd_shift_reg[6:0], 1'b0};
            end
            oe_next = cnt_reg < `FRAME_BITS;
          end
          if (rise && cnt_reg < `FRAME_BITS) begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
      endcase
    end
    if (regs_clear) begin
      vcom_next = `RST_VCOM;
      mode_next = `RST_MODE;
    end
    in_rst_next = !rst_s.level;
    if (!i_rst_b) begin
      state_next = ST_IDLE;
      cnt_next = 5'h00;
      shift_next = 8'h00;
      addr_next = 7'h00;
      rd_shift_next = 8'h00;
      vcom_next = `RST_VCOM;
      mode_next = `RST_MODE;
      sda_next = 1'b0;
      oe_next = 1'b0;
      in_rst_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
    sclk_d_reg <= sclk_d_next;
    cnt_reg <= cnt_next;
    shift_reg <= shift_next;
    addr_reg <= addr_next;
    rd_shift_reg <= rd_shift_next;
    vcom_reg <= vcom_next;
    mode_reg <= mode_next;
    sda_reg <= sda_next;
    oe_reg <= oe_next;
    in_rst_reg <= in_rst_next;
  end

  assign o_sda = sda_reg;
  assign o_sda_oe = oe_reg;
  assign o_vcom_amp_trim = vcom_reg[`VCOM_AMP_MSB:`VCOM_AMP_LSB];
  assign o_vcom_dc_level = vcom_reg[`VCOM_DC_MSB:`VCOM_DC_LSB];
  assign o_interface_mode_select = mode_reg[`MODE_SEL_BIT];
  assign o_regs_in_reset = in_rst_reg;
endmodule // panel_serial_register_port
`default_nettype wire

//--- panel_port_monitor.sv
// pin-level checks of the panel serial register port
`default_nettype none
module panel_port_monitor (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_hw_reset_low_pin,
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic [2:0] o_vcom_amp_trim,
  input wire logic [3:0] o_vcom_dc_level,
  input wire logic o_interface_mode_select,
  input wire logic o_regs_in_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence cs_idle; i_cs_b [*8]; endsequence
  sequence pin_low; !i_hw_reset_low_pin [*8]; endsequence
  // pins pass a 3-stage sampler, so the serial clock level is looked up 3 clocks back
  a_idle_undriven: assert property (cs_idle |-> !o_sda_oe)
    else $error("data driven while idle");
  a_drive_on_fall: assert property ($rose(o_sda_oe) |-> !$past(i_sclk, 3))
    else $error("drive began in high clock");
  a_shift_on_fall: assert property (o_sda_oe && $past(o_sda_oe) && $changed(o_sda)
    |-> !$past(i_sclk, 3)) else $error("data moved in high clock");
  a_release_done: assert property ($fell(o_sda_oe)
    |-> !$past(i_sclk, 3) || $past(i_cs_b, 3)) else $error("release out of place");
  a_pin_defaults: assert property (pin_low |-> o_regs_in_reset && o_vcom_amp_trim == 3'h3
    && o_vcom_dc_level == 4'h8 && !o_interface_mode_select) else $error("reset values wrong");
  a_flag_clears: assert property (i_hw_reset_low_pin [*8] |-> !o_regs_in_reset)
    else $error("reset flag stuck");
  a_mode_in_frame: assert property ($changed(o_interface_mode_select)
    |-> !$past(i_cs_b) || !$past(i_hw_reset_low_pin, 2)) else $error("mode moved idle");
  a_vcom_in_frame: assert property ($changed({o_vcom_amp_trim, o_vcom_dc_level})
    |-> !$past(i_cs_b) || !$past(i_hw_reset_low_pin, 2)) else $error("vcom moved idle");
endmodule // panel_port_monitor
bind panel_serial_register_port panel_port_monitor panel_port_monitor_inst (.i_clk, .i_rst_b,
  .i_hw_reset_low_pin, .i_sclk, .i_cs_b, .o_sda, .o_sda_oe, .o_vcom_amp_trim, .o_vcom_dc_level,
  .o_interface_mode_select, .o_regs_in_reset);
`default_nettype wire

//--- panel_host_model.sv
// behavioural host that clocks frames over the three-wire port
`default_nettype none
module panel_host_model (
  input wire logic i_clk,
  input wire logic i_dev_sda,
  input wire logic i_dev_oe,
  output var logic o_sclk = 1'b0,
  output var logic o_cs_b = 1'b1,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic val = 1'b0;
  logic last = 1'b0;
  // an undriven wire toggles so a stale bit can never pass for data
  assign o_sda = drv ? val : (i_dev_oe ? i_dev_sda : ~last);
  always @(posedge i_clk) last <= o_sda;
  task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d, input int cut,
                       output logic [7:0] q);
    logic [15:0] w;
    w = {rw, a, d};
    q = 8'h00;
    @(posedge i_clk);
    o_cs_b <= 1'b0;
    drv <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      o_sclk <= 1'b0;
      val <= w[i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      // let go of the line on the last command bit's rising edge, never later
      if (rw && i == 8) drv <= 1'b0;
      repeat (2) @(posedge i_clk);
      @(posedge i_clk);
      if (i < 8) q[i] = o_sda;
      @(posedge i_clk);
      if (i == cut) break;
    end
    o_sclk <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_cs_b <= 1'b1;
    drv <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask
endmodule // panel_host_model
`default_nettype wire

//--- testbench.sv
// self-checking bench for the panel serial register port
`include "panel_port_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, hw_b = 1'b1, tog = 1'b0;
  logic sclk, cs_b, sda, dsda, doe, mode, busy;
  logic [2:0] amp;
  logic [3:0] dc;
  logic [7:0] rq, cur;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h1425;
  int errors = 0, checked = 0;
  always #5 clk = ~clk;
  panel_serial_register_port panel_serial_register_port_inst (.i_clk(clk), .i_rst_b(rst_b),
    .i_hw_reset_low_pin(hw_b), .i_sclk(sclk), .i_cs_b(cs_b), .i_sda(sda), .o_sda(dsda),
    .o_sda_oe(doe), .o_vcom_amp_trim(amp), .o_vcom_dc_level(dc),
    .o_interface_mode_select(mode), .o_regs_in_reset(busy));
  panel_host_model panel_host_model_inst (.i_clk(clk), .i_dev_sda(dsda), .i_dev_oe(doe),
    .o_sclk(sclk), .o_cs_b(cs_b), .o_sda(sda));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  always @(tog) chk("read data", rq, exp_q.pop_front());
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    panel_host_model_inst.frame(1'b0, a, d, -1, cur);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    panel_host_model_inst.frame(1'b1, a, 8'h00, -1, rq);
    tog = ~tog;
  endtask
  task automatic end_of_test();
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`ADDR_IDENT, {2'h0, `PART_ID_DEF, `REV_ID_DEF});
    wr(`ADDR_IDENT, 8'hFF);
    rd(`ADDR_IDENT, {2'h0, `PART_ID_DEF, `REV_ID_DEF});
    rd(`ADDR_VCOM, `RST_VCOM);
    rd(`ADDR_READ_MAX, 8'h00);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wr(`ADDR_VCOM, seed[7:0]);
      wr(`ADDR_MODE, seed[15:8]);
      rd(`ADDR_VCOM, seed[7:0]);
      rd(`ADDR_MODE, seed[15:8]);
      chk("vcom pins", {1'b0, amp, dc}, {1'b0, seed[7:5], seed[3:0]});
      chk("mode pin", {7'h00, mode}, {7'h00, seed[8]});
    end
    // a select break after eleven bits must leave no trace in the next frame
    panel_host_model_inst.frame(1'b0, `ADDR_VCOM, 8'h11, 5, cur);
    rd(`ADDR_VCOM, seed[7:0]);
    wr(`ADDR_VCOM, 8'h11);
    rd(`ADDR_VCOM, 8'h11);
    wr(`ADDR_SWRST, 8'h00);
    rd(`ADDR_VCOM, 8'h11);
    wr(`ADDR_SWRST, 8'h01);
    rd(`ADDR_MODE, `RST_MODE);
    wr(`ADDR_VCOM, 8'hA5);
    hw_b <= 1'b0;
    repeat (10) @(posedge clk);
    hw_b <= 1'b1;
    repeat (10) @(posedge clk);
    rd(`ADDR_VCOM, `RST_VCOM);
    @(posedge clk);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
